// ---- design/ata_command_decoder.sv ----
// command decode and execution control for the write half of the command set
// assumes the host holds opcode/feature/count/lba stable while cmd_valid
// Contract
// - reject accesses beyond limit; report limit
// - extended max-address opcode, same enforcement
// - latch feature parameters for later use
// - store block count for multiple commands
// - sleep: busy, enter sleep, clear, interrupt
// - return health data or log data
// - report reliability status
// - enable or disable attribute autosave
// - start offline collection or self-test
// - enable monitoring; off until enabled
// - disable monitoring and attribute autosave
// - abort monitoring commands while disabled
// - standby: busy, enter standby, interrupt
// - write buffer overwritten by host data
// - dma write 1..256, zero means 256
// - extended dma write, zero means 65536
// - multiple writes interrupt per block
// - pio write 1..256, zero means 256
// - extended pio write, zero means 65536
// - write without erase, 1..256 sectors
// - write verify checks before completion
`timescale 1ns/1ns
module ata_command_decoder
  import ata_cmd_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          clock,
  input  wire logic          rst,
  // ===== command port
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic [7:0]    cmd_opcode,
  input  wire logic [7:0]    cmd_feature,
  input  wire logic [15:0]   cmd_count,
  input  wire logic [47:0]   cmd_lba,
  // ===== host write data
  input  wire logic          wdata_valid,
  output logic               wdata_ready,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wdata_last,
  // ===== media side write data
  output logic               mdata_valid,
  input  wire logic          mdata_ready,
  output logic [DW-1:0]      mdata,
  output logic               mdata_last,
  output logic               mdata_to_buffer,
  input  wire logic          verify_ok,
  // ===== status
  output logic               busy_flag,
  output logic               intrq,
  output logic               abort_error,
  output logic               id_not_found_error,
  output logic [1:0]         power_mode,
  output logic [7:0]         feature_param,
  output logic [7:0]         block_size,
  output logic [47:0]        max_lba,
  output logic [15:0]        ident_word60,
  output logic [15:0]        ident_word61,
  output logic               health_enabled,
  output logic               autosave_enabled,
  output logic               offline_start,
  output logic [2:0]         health_reply,
  output logic               dma_mode,
  output logic [16:0]        xfer_sectors
);
  // ===========================================================
  // opcode decode
  wire is_set_max  = cmd_opcode == OP_SET_MAX
                  || cmd_opcode == OP_SET_MAX_EXT;
  wire is_sleep    = cmd_opcode == OP_SLEEP_A || cmd_opcode == OP_SLEEP_B;
  wire is_standby  = cmd_opcode == OP_STANDBY
                  || cmd_opcode == OP_STANDBY_IMM;
  wire is_dma_s    = cmd_opcode == OP_WR_DMA_A || cmd_opcode == OP_WR_DMA_B;
  wire is_mult     = cmd_opcode == OP_WR_MULT
                  || cmd_opcode == OP_WR_MULT_EXT;
  wire is_long     = cmd_opcode == OP_WR_DMA_EXT
                  || cmd_opcode == OP_WR_SECT_EXT
                  || cmd_opcode == OP_WR_MULT_EXT;
  wire is_write    = is_dma_s || is_mult || is_long
                  || cmd_opcode == OP_WR_SECT
                  || cmd_opcode == OP_WR_NO_ERASE
                  || cmd_opcode == OP_WR_VERIFY;
  wire is_buf      = cmd_opcode == OP_WRITE_BUF;
  wire is_health   = cmd_opcode == OP_HEALTH;
  wire is_known    = is_set_max || is_sleep || is_standby || is_write
                  || is_buf || is_health
                  || cmd_opcode == OP_SET_FEATURE
                  || cmd_opcode == OP_SET_MULT;
  // feature decode for the monitoring family
  wire hf_known    = cmd_feature == HF_READ_DATA
                  || cmd_feature == HF_AUTOSAVE
                  || cmd_feature == HF_OFFLINE
                  || cmd_feature == HF_READ_LOG
                  || cmd_feature == HF_ENABLE
                  || cmd_feature == HF_DISABLE
                  || cmd_feature == HF_STATUS;
  // while disabled only the enable sub-command survives
  wire hf_abort    = !hf_known
                  || (!health_enabled && cmd_feature != HF_ENABLE);
  // ===========================================================
  // sector count: zero means full range
  wire [16:0] cnt_short = (cmd_count[7:0] == 8'h00) ? CNT_SHORT_ZERO
                        : {9'h000, cmd_count[7:0]};
  wire [16:0] cnt_long  = (cmd_count == 16'h0000) ? CNT_LONG_ZERO
                        : {1'b0, cmd_count};
  wire [16:0] cnt_sel   = is_long ? cnt_long : cnt_short;
  // last sector addressed must lie within the limit
  wire [48:0] lba_end   = {1'b0, cmd_lba} + {32'h0000_0000, cnt_sel}
                        - 49'h0_0000_0000_0001;
  wire        out_range = lba_end > {1'b0, max_lba};
  // ===========================================================
  // state registers
  state_t      state_r, state_nxt;
  logic [16:0] left_r;          // sectors still to move
  logic [7:0]  blk_left_r;      // sectors until next block interrupt
  logic        mult_r;          // current command is a multiple write
  logic        verify_r;        // current command verifies each sector
  logic        buf_r;           // current command targets sector buffer
  logic        accept;
  assign cmd_ready = state_r == ST_IDLE;
  assign accept    = cmd_valid && cmd_ready;
  assign busy_flag = state_r != ST_IDLE;
  assign ident_word60 = max_lba[15:0];
  assign ident_word61 = max_lba[31:16];
  // ===========================================================
  // two-entry skid buffer toward the media side
  logic [DW-1:0] sk_d [2];
  logic          sk_l [2];
  logic [1:0]    sk_n;
  logic          sk_in, sk_out, xfer_on;
  assign xfer_on     = state_r == ST_XFER;
  assign wdata_ready = xfer_on && sk_n != 2'd2;
  assign sk_in       = wdata_valid && wdata_ready;
  assign mdata_valid = sk_n != 2'd0;
  assign mdata       = sk_d[0];
  assign mdata_last  = sk_l[0];
  assign sk_out      = mdata_valid && mdata_ready;
  // fill and drain; entry 0 is always the head
  always_ff @(posedge clock) begin
    if (rst) begin
      sk_n <= 2'd0;
    end else begin
      sk_n <= sk_n + {1'b0, sk_in} - {1'b0, sk_out};
    end
  end
  // data shifts toward the head when it leaves
  always_ff @(posedge clock) begin
    if (sk_out) begin
      sk_d[0] <= (sk_n == 2'd2) ? sk_d[1] : wdata;
      sk_l[0] <= (sk_n == 2'd2) ? sk_l[1] : wdata_last;
    end else if (sk_in && sk_n == 2'd0) begin
      sk_d[0] <= wdata;
      sk_l[0] <= wdata_last;
    end
    if (sk_in && (sk_n == 2'd2 || (sk_n == 2'd1 && !sk_out))) begin
      sk_d[1] <= wdata;
      sk_l[1] <= wdata_last;
    end
  end
  // a sector ends when its last word reaches the media side
  wire sect_done = sk_out && sk_l[0];
  // ===========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (accept) begin
        if (!is_known || (is_health && hf_abort)) begin
          state_nxt = ST_DONE;
        end else if (is_write && out_range) begin
          state_nxt = ST_DONE;
        end else if (is_write || is_buf) begin
          state_nxt = ST_XFER;
        end else begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY:  state_nxt = ST_DONE;
      ST_XFER:  if (sect_done) begin
        state_nxt = verify_r ? ST_VERIF
                  : (left_r == 17'h00001 ? ST_DONE : ST_XFER);
      end
      ST_VERIF: state_nxt = (left_r == 17'h00000 || !verify_ok)
                  ? ST_DONE : ST_XFER;
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end
  // ===========================================================
  // command execution and status
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r            <= ST_IDLE;
      left_r             <= 17'h00000;
      blk_left_r         <= 8'h00;
      mult_r             <= 1'b0;
      verify_r           <= 1'b0;
      buf_r              <= 1'b0;
      intrq              <= 1'b0;
      abort_error        <= 1'b0;
      id_not_found_error <= 1'b0;
      power_mode         <= PM_ACTIVE;
      feature_param      <= 8'h00;
      block_size         <= MULT_RESET;
      max_lba            <= MAX_LBA_RESET;
      health_enabled     <= 1'b0;
      autosave_enabled   <= 1'b0;
      offline_start      <= 1'b0;
      health_reply       <= 3'b000;
      dma_mode           <= 1'b0;
      xfer_sectors       <= 17'h00000;
      mdata_to_buffer    <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      intrq         <= 1'b0;
      offline_start <= 1'b0;
      health_reply  <= 3'b000;
      if (accept) begin
        abort_error        <= !is_known || (is_health && hf_abort);
        id_not_found_error <= is_write && out_range && is_known;
        power_mode         <= PM_ACTIVE;
        mult_r             <= is_mult;
        verify_r           <= cmd_opcode == OP_WR_VERIFY;
        buf_r              <= is_buf;
        mdata_to_buffer    <= is_buf;
        dma_mode           <= is_dma_s || cmd_opcode == OP_WR_DMA_EXT;
        left_r             <= is_buf ? 17'h00001 : cnt_sel;
        xfer_sectors       <= is_buf ? 17'h00001 : cnt_sel;
        blk_left_r         <= block_size;
        if (is_set_max) begin
          max_lba <= cmd_lba;
        end
        if (cmd_opcode == OP_SET_FEATURE) begin
          feature_param <= cmd_feature;
        end
        if (cmd_opcode == OP_SET_MULT) begin
          block_size <= cmd_count[7:0];
        end
        if (is_sleep) begin
          power_mode <= PM_SLEEP;
        end
        if (is_standby) begin
          power_mode <= PM_STANDBY;
        end
        if (is_health && !hf_abort) begin
          unique case (cmd_feature)
            HF_READ_DATA: health_reply <= 3'b001;
            HF_READ_LOG:  health_reply <= 3'b010;
            HF_STATUS:    health_reply <= 3'b100;
            HF_AUTOSAVE:  autosave_enabled <= cmd_count[7:0] != 8'h00;
            HF_OFFLINE:   offline_start <= 1'b1;
            HF_ENABLE:    health_enabled <= 1'b1;
            HF_DISABLE: begin
              health_enabled   <= 1'b0;
              autosave_enabled <= 1'b0;
            end
            default:      health_reply <= 3'b000;
          endcase
        end
      end
      // per-sector bookkeeping
      if (xfer_on && sect_done) begin
        left_r <= left_r - 17'h00001;
        if (mult_r) begin
          // interrupt per block, not per sector
          if (blk_left_r == 8'h01 && left_r != 17'h00001) begin
            intrq      <= 1'b1;
            blk_left_r <= block_size;
          end else begin
            blk_left_r <= blk_left_r - 8'h01;
          end
        end
      end
      // a failed compare ends the command with an abort
      if (state_r == ST_VERIF && !verify_ok) begin
        abort_error <= 1'b1;
      end
      // completion interrupt, also for aborts
      if (state_r == ST_DONE) begin
        intrq <= 1'b1;
      end
    end
  end
  // buf_r is only tied to unused_buf; no completion logic reads it
  wire unused_buf = buf_r;
endmodule

// ---- design/ata_cmd_pkg.sv ----
// constants shared by the command decoder and its bench
// assumes a single 10 MHz clock domain and a task-file style command port
package ata_cmd_pkg;
  // ===========================================================
  // opcodes
  localparam logic [7:0] OP_SET_MAX      = 8'hF9;
  localparam logic [7:0] OP_SET_MAX_EXT  = 8'h37;
  localparam logic [7:0] OP_SET_FEATURE  = 8'hEF;
  localparam logic [7:0] OP_SET_MULT     = 8'hC6;
  localparam logic [7:0] OP_SLEEP_A      = 8'h99;
  localparam logic [7:0] OP_SLEEP_B      = 8'hE6;
  localparam logic [7:0] OP_HEALTH       = 8'hB0;
  localparam logic [7:0] OP_STANDBY      = 8'hE2;
  localparam logic [7:0] OP_STANDBY_IMM  = 8'hE0;
  localparam logic [7:0] OP_WRITE_BUF    = 8'hE8;
  localparam logic [7:0] OP_WR_DMA_A     = 8'hCA;
  localparam logic [7:0] OP_WR_DMA_B     = 8'hCB;
  localparam logic [7:0] OP_WR_DMA_EXT   = 8'h35;
  localparam logic [7:0] OP_WR_MULT      = 8'hC5;
  localparam logic [7:0] OP_WR_MULT_EXT  = 8'h39;
  localparam logic [7:0] OP_WR_SECT      = 8'h30;
  localparam logic [7:0] OP_WR_SECT_EXT  = 8'h34;
  localparam logic [7:0] OP_WR_NO_ERASE  = 8'h38;
  localparam logic [7:0] OP_WR_VERIFY    = 8'h3C;
  // ===========================================================
  // health-monitoring feature values
  localparam logic [7:0] HF_READ_DATA    = 8'hD0;
  localparam logic [7:0] HF_AUTOSAVE     = 8'hD2;
  localparam logic [7:0] HF_OFFLINE      = 8'hD4;
  localparam logic [7:0] HF_READ_LOG     = 8'hD5;
  localparam logic [7:0] HF_ENABLE       = 8'hD8;
  localparam logic [7:0] HF_DISABLE      = 8'hD9;
  localparam logic [7:0] HF_STATUS       = 8'hDA;
  // ===========================================================
  // reset values, identify word positions and zero-count sector totals
  localparam logic [7:0]  MULT_RESET     = 8'h01;
  localparam logic [47:0] MAX_LBA_RESET  = 48'hFFFF_FFFF_FFFF;
  localparam int          ID_WORD_LO     = 60;
  localparam int          ID_WORD_HI     = 61;
  localparam logic [16:0] CNT_SHORT_ZERO = 17'h00100;
  localparam logic [16:0] CNT_LONG_ZERO  = 17'h10000;
  // ===========================================================
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BUSY  = 3'b001,
    ST_XFER  = 3'b010,
    ST_VERIF = 3'b011,
    ST_DONE  = 3'b100
  } state_t;
  // power modes reported on power_mode
  typedef enum logic [1:0] {
    PM_ACTIVE  = 2'b00,
    PM_STANDBY = 2'b01,
    PM_SLEEP   = 2'b10
  } power_t;
endpackage

// ---- bench/ata_command_decoder_asserts.sv ----
// port assertions for the command decoder
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ns
module ata_command_decoder_asserts
  import ata_cmd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [7:0]  cmd_feature,
  input wire logic [15:0] cmd_count,
  input wire logic        busy_flag,
  input wire logic        intrq,
  input wire logic        abort_error,
  input wire logic [1:0]  power_mode,
  input wire logic [7:0]  block_size,
  input wire logic [47:0] max_lba,
  input wire logic [15:0] ident_word60,
  input wire logic [15:0] ident_word61,
  input wire logic        health_enabled
);
  // =====================================================
  // helpers
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire logic       acc    = cmd_valid && cmd_ready; // command taken
  wire logic [7:0] cnt_lo = cmd_count[7:0];         // block count byte
  wire logic       hcmd   = acc && cmd_opcode == OP_HEALTH;
  // idle means ready, so a busy device can never take a command
  AST_READY: assert property (busy_flag != cmd_ready)
    else $error("busy and ready disagree");
  AST_SLEEP: assert property (acc && (cmd_opcode == OP_SLEEP_A ||
    cmd_opcode == OP_SLEEP_B) |=> busy_flag && power_mode == PM_SLEEP
    ##2 intrq && !busy_flag) else $error("sleep sequence wrong");
  AST_STANDBY: assert property (acc && (cmd_opcode == OP_STANDBY ||
    cmd_opcode == OP_STANDBY_IMM) |=> busy_flag &&
    power_mode == PM_STANDBY ##2 intrq) else $error("standby wrong");
  AST_MULT: assert property (acc && cmd_opcode == OP_SET_MULT
    |=> ##1 block_size == $past(cnt_lo, 2)) else $error("block size");
  AST_IDENT: assert property ({ident_word61, ident_word60} ==
    max_lba[31:0]) else $error("identify words differ from limit");
  AST_HOFF: assert property (hcmd && !health_enabled &&
    cmd_feature != HF_ENABLE |=> abort_error ##1 intrq)
    else $error("disabled monitoring not aborted");
  AST_HON: assert property (hcmd && cmd_feature == HF_ENABLE
    |-> ##2 health_enabled) else $error("monitoring not enabled");
  AST_HDIS: assert property (hcmd && health_enabled &&
    cmd_feature == HF_DISABLE |-> ##2 !health_enabled)
    else $error("monitoring not disabled");
endmodule
bind ata_command_decoder ata_command_decoder_asserts chk_i (.clock, .rst,
  .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_feature, .cmd_count,
  .busy_flag, .intrq, .abort_error, .power_mode, .block_size, .max_lba,
  .ident_word60, .ident_word61, .health_enabled);

// ---- bench/media_sink.sv ----
// media-side sink for the decoder's write words
// assumes one clock; stalls and verify faults only when the bench asks
`timescale 1ns/1ns
module media_sink (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic bad_verify,
  input  wire logic mdata_valid,
  input  wire logic mdata_last,
  output logic      mdata_ready,
  output logic      verify_ok,
  output int        n_sect
);
  // =====================================================
  // stall phase: when stalling, take one word in four
  logic [1:0] ph_r;
  assign mdata_ready = !stall || ph_r == 2'h3;
  assign verify_ok   = !bad_verify; // a fault only on request
  // count whole sectors as their last word is taken
  always_ff @(posedge clock) begin
    ph_r <= rst ? 2'h0 : ph_r + 2'h1;
    if (rst)
      n_sect <= 0;
    else if (mdata_valid && mdata_ready && mdata_last)
      n_sect <= n_sect + 1;
  end
endmodule

// ---- bench/test_ata_command_decoder.sv ----
// self-checking bench for the command decoder
// assumes the package constants and the media sink partner
`timescale 1ns/1ns
module test_ata_command_decoder;
  import ata_cmd_pkg::*;
  // =====================================================
  // signals
  logic             clock, rst, cmd_valid, wdata_valid, wdata_last;
  logic             stall, bad_verify;
  logic [7:0]       cmd_opcode, cmd_feature;
  logic [15:0]      cmd_count, wdata;
  logic [47:0]      cmd_lba;
  wire logic        cmd_ready, wdata_ready, mdata_valid, mdata_ready;
  wire logic        mdata_last, mdata_to_buffer, verify_ok, busy_flag;
  wire logic        intrq, abort_error, id_not_found_error, dma_mode;
  wire logic        health_enabled, autosave_enabled;
  wire logic [1:0]  power_mode;
  wire logic [7:0]  feature_param, block_size;
  wire logic [47:0] max_lba;
  wire logic [16:0] xfer_sectors;
  int n_sect, failures = 0, n_compared = 0, cyc = 0, n_irq = 0, s0, q0;
  logic [7:0] pop [4] = '{OP_SLEEP_A, OP_SLEEP_B, OP_STANDBY,
    OP_STANDBY_IMM};
  logic [7:0] wop [8] = '{OP_WR_SECT, OP_WR_NO_ERASE, OP_WR_VERIFY,
    OP_WR_DMA_A, OP_WR_DMA_B, OP_WRITE_BUF, OP_WR_DMA_EXT, OP_WR_SECT_EXT};
  logic [7:0] hop [4] = '{HF_READ_DATA, HF_READ_LOG, HF_STATUS, HF_OFFLINE};
  ata_command_decoder dut (.clock, .rst, .cmd_valid, .cmd_ready,
    .cmd_opcode, .cmd_feature, .cmd_count, .cmd_lba, .wdata_valid,
    .wdata_ready, .wdata, .wdata_last, .mdata_valid, .mdata_ready,
    .mdata(), .mdata_last, .mdata_to_buffer, .verify_ok, .busy_flag,
    .intrq, .abort_error, .id_not_found_error, .power_mode, .feature_param,
    .block_size, .max_lba, .ident_word60(), .ident_word61(),
    .health_enabled, .autosave_enabled, .offline_start(),
    .health_reply(), .dma_mode, .xfer_sectors);
  media_sink sink (.clock, .rst, .stall, .bad_verify, .mdata_valid,
    .mdata_last, .mdata_ready, .verify_ok, .n_sect);
  // =====================================================
  // clock, timeout and interrupt count (sampled mid-cycle)
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    cyc++;
    if (intrq === 1'b1)
      n_irq++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one command, then ns two-word sectors, then wait for idle;
  // called and returns at a falling edge
  task automatic issue(input logic [7:0] op, ft, input logic [15:0] ct,
                       input logic [47:0] lb, input int ns);
    int k;
    {cmd_opcode, cmd_feature, cmd_count, cmd_lba} = {op, ft, ct, lb};
    cmd_valid = 1'b1;
    for (k = 0; cmd_ready !== 1'b1 && k < 9; k++) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    for (int s = 0; s < 2 * ns; s++) begin
      {wdata, wdata_last, wdata_valid} = {16'(s), s[0], 1'b1};
      for (k = 0; wdata_ready !== 1'b1 && k < 99; k++) @(negedge clock);
      @(negedge clock);
    end
    wdata_valid = 1'b0;
    for (k = 0; busy_flag !== 1'b0 && k < 99; k++) @(negedge clock);
    @(negedge clock); // let the completion pulse be counted
  endtask
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial begin
    {rst, cmd_valid, wdata_valid, wdata_last, stall, bad_verify} = 6'h20;
    {cmd_opcode, cmd_feature, cmd_count, cmd_lba, wdata} = '0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      s0 = n_irq;
      issue(pop[i], 8'h00, 16'h0000, 48'h0, 0);
      chk("power_mode", 48'(power_mode), i < 2 ? 48'h2 : 48'h1);
      chk("irq", 48'(n_irq - s0), 48'h1);
    end
    issue(OP_SET_FEATURE, 8'h5A, 16'h0000, 48'h0, 0);
    chk("feature_param", 48'(feature_param), 48'h5A);
    issue(OP_SET_MULT, 8'h00, 16'h0003, 48'h0, 0);
    stall = 1'b1; // the sink stalls so the buffer fills and refuses
    for (int i = 0; i < 2; i++) begin
      {s0, q0} = {n_irq, n_sect};
      issue(i == 0 ? OP_WR_MULT : OP_WR_MULT_EXT, 8'h0, 16'h6, 48'h0, 6);
      chk("block irq", 48'(n_irq - s0), 48'h2);
      chk("sectors", 48'(n_sect - q0), 48'h6);
    end
    for (int i = 0; i < 8; i++) begin
      q0 = n_sect;
      issue(wop[i], 8'h0, 16'h1, 48'h10, 1);
      chk("sectors", 48'(n_sect - q0), 48'h1);
      chk("xfer", 48'(xfer_sectors), 48'h1);
      chk("dma_mode", 48'(dma_mode), 48'(i inside {3, 4, 6}));
      chk("to_buffer", 48'(mdata_to_buffer), 48'(i == 5));
    end
    for (int i = 0; i < 2; i++) begin
      q0 = n_sect;
      issue(i == 0 ? OP_WR_DMA_A : OP_WR_SECT, 8'h0, 16'h0, 48'h0, 256);
      chk("zero count", 48'(n_sect - q0), 48'd256);
    end
    bad_verify = 1'b1;
    issue(OP_WR_VERIFY, 8'h0, 16'h1, 48'h0, 1);
    chk("verify abort", 48'(abort_error), 48'h1);
    {bad_verify, stall} = 2'h0;
    issue(OP_SET_MAX_EXT, 8'h0, 16'h0, 48'hABCD_0123_4567, 0);
    issue(OP_WR_DMA_EXT, 8'h0, 16'h1, 48'hABCD_0123_4568, 0);
    chk("id_not_found_error", 48'(id_not_found_error), 48'h1);
    issue(OP_SET_MAX, 8'h0, 16'h0, 48'h40, 0);
    chk("max_lba", max_lba, 48'h40);
    issue(OP_WR_SECT, 8'h0, 16'h2, 48'h40, 0);
    chk("id_not_found_error", 48'(id_not_found_error), 48'h1);
    issue(OP_WR_SECT, 8'h0, 16'h1, 48'h40, 1);
    chk("id_not_found_error", 48'(id_not_found_error), 48'h0);
    issue(OP_HEALTH, HF_READ_DATA, 16'h0, 48'h0, 0);
    chk("abort", 48'(abort_error), 48'h1);
    issue(OP_HEALTH, HF_ENABLE, 16'h0, 48'h0, 0);
    for (int i = 0; i < 4; i++) begin
      issue(OP_HEALTH, hop[i], 16'h0, 48'h0, 0);
      chk("abort", 48'(abort_error), 48'h0);
    end
    for (int i = 1; i >= 0; i--) begin
      issue(OP_HEALTH, HF_AUTOSAVE, 16'(i), 48'h0, 0);
      chk("autosave", 48'(autosave_enabled), 48'(i));
    end
    s0 = n_irq;
    issue(OP_HEALTH, 8'hC0, 16'h0, 48'h0, 0);
    chk("abort", 48'(abort_error), 48'h1);
    chk("irq", 48'(n_irq - s0), 48'h1);
    issue(OP_HEALTH, HF_DISABLE, 16'h0, 48'h0, 0);
    issue(OP_HEALTH, HF_DISABLE, 16'h0, 48'h0, 0);
    chk("abort", 48'(abort_error), 48'h1);
    issue(8'h00, 8'h0, 16'h0, 48'h0, 0);
    chk("abort", 48'(abort_error), 48'h1);
    end_of_test();
  end
endmodule
